// ===== lcd_driver_init_sequencer.v
// command decode, display and icon enables of a character lcd driver
`timescale 1ns/1ps
`include "lcd_init_defines.vh"
module lcd_driver_init_sequencer #(
   parameter GLYPHS   = `GLYPH_COUNT,
   parameter HOLD_CYC = `SER_HOLD_CYC
) (
   input  wire       clk,
   input  wire       rst,
   input  wire       chip_clear_pin_n,
   input  wire [1:0] bus_mode,
   input  wire       cs_n,
   input  wire       a0,
   input  wire       wr_n,
   input  wire       e,
   input  wire [7:0] d_in,
   input  wire       scl,
   input  wire       si,
   output reg        cmd_valid,
   output reg        cmd_is_data,
   output reg  [7:0] cmd_byte,
   output reg        ready,
   output reg        test_mode,
   output reg        saver_bit,
   output reg        osc_on,
   output reg        display_on,
   output reg        power_circuit_on,
   output reg  [3:0] icon_on,
   output reg        icon_error,
   output reg  [9:0] glyph_count
);
   // host styles
   localparam MODE_80 = 2'h0;
   localparam MODE_68 = 2'h1;
   localparam MODE_SER = 2'h2;

   // one-hot states
   localparam ST_CLEAR = 3'b001;
   localparam ST_RUN   = 3'b010;
   localparam ST_ICON  = 3'b100;

   reg [2:0]  state_q;
   reg        wr_q;
   reg        e_q;
   reg        scl_q;
   reg [7:0]  shift_q;
   reg [2:0]  bit_q;
   reg        a0_q;
   reg        ser_full_q;
   reg [15:0] hold_q;
   reg        byte_stb;
   reg        byte_a0;
   reg [7:0]  byte_val;
   reg [1:0]  icon_addr_q;
   wire       cmd_take;
   wire       icon_take;

   // commands in either state, icon data only right after an icon command
   assign cmd_take  = byte_stb && !byte_a0;
   assign icon_take = byte_stb && byte_a0 && (state_q == ST_ICON);

   // opcode nibble of a command byte
   function [3:0] opcode;
      input [7:0] b;
      begin
         opcode = b[7:4];
      end
   endfunction

   // strobe detection per host style
   always @* begin
      byte_stb = 1'b0;
      byte_a0  = a0;
      byte_val = d_in;
      case (bus_mode)
         MODE_80: byte_stb = !cs_n && !wr_q && wr_n;
         MODE_68: byte_stb = !cs_n && e_q && !e;
         MODE_SER: begin
            byte_stb = ser_full_q && (hold_q >= HOLD_CYC[15:0]);
            byte_a0  = a0_q;
            byte_val = shift_q;
         end
         default: byte_stb = 1'b0;
      endcase
   end

   // serial shift and select hold check
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_q       <= 1'b1;
         e_q        <= 1'b0;
         scl_q      <= 1'b1;
         shift_q    <= 8'h00;
         bit_q      <= 3'h0;
         a0_q       <= 1'b0;
         ser_full_q <= 1'b0;
         hold_q     <= 16'h0000;
      end else begin
         // edge history of the host strobes
         wr_q  <= wr_n;
         e_q   <= e;
         scl_q <= scl;
         if (cs_n || bus_mode != MODE_SER) begin
            bit_q      <= 3'h0;
            ser_full_q <= 1'b0;
            hold_q     <= 16'h0000;
         end else if (!scl_q && scl) begin
            shift_q <= {shift_q[6:0], si};
            bit_q   <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
               a0_q       <= a0;
               ser_full_q <= 1'b1;
               hold_q     <= 16'h0000;
            end else begin
               ser_full_q <= 1'b0;
            end
         end else if (ser_full_q) begin
            if (byte_stb)
               ser_full_q <= 1'b0;
            else
               hold_q <= hold_q + 16'h0001;
         end
      end
   end

   // command state
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q          <= ST_CLEAR;
         cmd_valid        <= 1'b0;
         cmd_is_data      <= 1'b0;
         cmd_byte         <= 8'h00;
         ready            <= 1'b0;
         test_mode        <= 1'b0;
         saver_bit        <= 1'b1;
         osc_on           <= 1'b0;
         display_on       <= 1'b0;
         power_circuit_on <= 1'b0;
         icon_on          <= 4'h0;
         icon_error       <= 1'b0;
         glyph_count      <= 10'h000;
         icon_addr_q      <= 2'h0;
      end else begin
         cmd_valid   <= 1'b0;
         glyph_count <= GLYPHS[9:0];
         // clear pin wins over any command
         if (!chip_clear_pin_n) begin
            state_q          <= ST_CLEAR;
            ready            <= 1'b0;
            test_mode        <= 1'b1;
            saver_bit        <= 1'b1;
            osc_on           <= 1'b0;
            display_on       <= 1'b0;
            power_circuit_on <= 1'b0;
            icon_on          <= 4'h0;
            icon_error       <= 1'b0;
            icon_addr_q      <= 2'h0;
         end else begin
            case (state_q)
               // bytes are taken from the cycle after release
               ST_CLEAR: begin
                  state_q <= ST_RUN;
                  ready   <= 1'b1;
               end
               ST_RUN, ST_ICON: begin
                  if (byte_stb) begin
                     cmd_valid   <= 1'b1;
                     cmd_is_data <= byte_a0;
                     cmd_byte    <= byte_val;
                     state_q     <= ST_RUN;
                  end
                  // icon byte lands on the address of its command
                  if (icon_take)
                     icon_on[icon_addr_q] <= |byte_val[4:0];
                  if (cmd_take) begin
                     // a command also ends a pending icon write
                     case (opcode(byte_val))
                        `OP_IDLE: test_mode <= 1'b0;
                        `OP_POWER_SAVE: begin
                           saver_bit <= byte_val[1];
                           osc_on    <= byte_val[0];
                        end
                        `OP_DISPLAY: display_on <= byte_val[0];
                        `OP_POWER_CIRCUIT: power_circuit_on <= byte_val[0];
                        `OP_ICON: begin
                           icon_addr_q <= byte_val[1:0];
                           if (!osc_on)
                              icon_error <= 1'b1;
                           else
                              state_q <= ST_ICON;
                        end
                        default: state_q <= ST_RUN;
                     endcase
                  end
               end
               default: state_q <= ST_CLEAR;
            endcase
         end
      end
   end
endmodule // lcd_driver_init_sequencer

// ===== lcd_init_defines.vh
// constants for the character lcd driver command front end
`ifndef LCD_INIT_DEFINES_VH
`define LCD_INIT_DEFINES_VH
`define CLK_MHZ            200
`define FIRST_CMD_WAIT_US  20
`define FIRST_CMD_WAIT_CYC ((`FIRST_CMD_WAIT_US * `CLK_MHZ))
`define SER_HOLD_NS        500
`define SER_HOLD_CYC       ((`SER_HOLD_NS * `CLK_MHZ + 999) / 1000)
`define GLYPH_COUNT        544
`define ICON_COUNT         4
`define OP_IDLE            4'h0
`define OP_SYS_SET         4'h1
`define OP_POWER_SAVE      4'h2
`define OP_DISPLAY         4'h3
`define OP_ICON            4'h4
`define OP_POWER_CIRCUIT   4'h5
`define OP_DATA            4'h6
`define BLANK_CHAR         8'h20
`endif

// ===== lcd_drv_asserts.sv
// checker for the lcd driver command front end
`timescale 1ns/1ps
module lcd_drv_checker #(parameter GLYPHS = 544) (
   input wire       clk,
   input wire       rst,
   input wire       chip_clear_pin_n,
   input wire       cmd_valid,
   input wire       cmd_is_data,
   input wire [7:0] cmd_byte,
   input wire       ready,
   input wire       test_mode,
   input wire       display_on,
   input wire [3:0] icon_on,
   input wire [9:0] glyph_count
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_clear_forces_off:
      assert property (!chip_clear_pin_n [*2] |-> test_mode && !display_on && icon_on == 4'h0) else $error("clear");
   a_idle_ends_test:
      assert property (cmd_valid && !cmd_is_data && cmd_byte[7:4] == 4'h0 |-> ##[0:1] !test_mode) else $error("idle");
   a_display_by_cmd:
      assert property ($rose(display_on) |-> cmd_valid || $past(cmd_valid)) else $error("display");
   a_icon_by_data:
      assert property ((icon_on & ~$past(icon_on)) != 4'h0 |-> $past(cmd_valid && cmd_is_data, 1)
         || cmd_valid && cmd_is_data) else $error("icon");
   a_valid_one_cycle:
      assert property (cmd_valid |=> !cmd_valid) else $error("pulse");
   a_glyph_count:
      assert property (ready |-> glyph_count == GLYPHS) else $error("glyphs");
   cover property (cmd_valid && cmd_is_data);
   cover property ($rose(display_on));
   cover property ($rose(icon_on[3]));
endmodule // lcd_drv_checker
bind lcd_driver_init_sequencer lcd_drv_checker #(.GLYPHS(GLYPHS)) u_chk (.*);

// ===== host_model.sv
// host bus model feeding the lcd driver
`timescale 1ns/1ps
module host_model (
   input  wire        clk,
   output logic       cs_n,
   output logic       a0,
   output logic       wr_n,
   output logic       e,
   output logic [7:0] d_in,
   output logic       scl,
   output logic       si
);
   initial {cs_n, a0, wr_n, e, d_in, scl, si} = {4'b1010, 8'h00, 2'b10}; // pins defined from the start
   task automatic par(input logic m, input logic c, input logic [7:0] b);
      @(posedge clk) {cs_n, a0, d_in} <= {1'b0, c, b};
      if (m) e <= 1'b1;
      else wr_n <= 1'b0;
      @(posedge clk) {e, wr_n} <= 2'b01;
      @(posedge clk) {cs_n, d_in} <= {1'b1, ~b};
   endtask
   task automatic ser(input logic c, input logic [7:0] b, input int h);
      @(posedge clk) {cs_n, a0} <= {1'b0, c};
      for (int i = 7; i >= 0; i--) begin // msb first
         @(posedge clk) {scl, si} <= {1'b0, b[i]};
         @(posedge clk) scl <= 1'b1;
      end
      repeat (h) @(posedge clk); // select held past last bit
      @(posedge clk) {cs_n, si} <= {1'b1, ~b[0]};
   endtask
endmodule // host_model

// ===== lcd_driver_init_sequencer_tb.sv
// self-checking bench for the lcd driver command front end
`timescale 1ns/1ps
`include "lcd_init_defines.vh"
module lcd_driver_init_sequencer_tb;
   logic       clk = 0, rst = 1, chip_clear_pin_n = 0;
   logic [1:0] bus_mode = 2'h0;
   logic [7:0] b;
   logic [9:0] exp_i;
   wire        cs_n, a0, wr_n, e, scl, si, cmd_valid, cmd_is_data, ready, test_mode;
   wire        saver_bit, osc_on, display_on, power_circuit_on, icon_error;
   wire  [7:0] d_in, cmd_byte;
   wire  [3:0] icon_on;
   wire  [9:0] glyph_count;
   int         fail_count = 0, num_checks = 0, seen = 0;
   localparam int PWR_WAIT = 2000; // settle wait counted in host clock cycles, shortened for the bench
   host_model u_host (.*);
   lcd_driver_init_sequencer #(.HOLD_CYC(2)) u_dut (.*);
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) if (cmd_valid === 1'b1) seen <= seen + 1;
   task chk(input string n, input logic [9:0] x, input logic [9:0] g);
      num_checks++;
      if (g !== x) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, x, g);
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   function automatic logic [9:0] icon_bit(input int k, input logic [7:0] d);
      return (|d[4:0]) ? 10'h1 << k : 10'h0;
   endfunction
   task clear;
      @(posedge clk) chip_clear_pin_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk("ready", 10'h0, {9'h0, ready});
      chip_clear_pin_n <= 1'b1;
      repeat (`FIRST_CMD_WAIT_CYC) @(posedge clk); // twenty us before first command
   endtask
   task send(input logic [1:0] m, input logic c, input logic [7:0] v);
      int n;
      n = seen;
      bus_mode <= m;
      if (m == 2'h2) u_host.ser(c, v, 3);
      else u_host.par(m[0], c, v);
      repeat (3) @(posedge clk);
      chk("count", 10'(n + 1), 10'(seen));
      chk("byte", {1'b0, c, v}, {1'b0, cmd_is_data, cmd_byte});
   endtask
   initial begin
      void'($urandom(32'h7e888940));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      clear();
      chk("test", 10'h1, {9'h0, test_mode});
      chk("ready", 10'h1, {9'h0, ready});
      chk("glyphs", 10'd544, glyph_count);
      send(2'h0, 1'b0, 8'h40);
      chk("icon_err", 10'h1, {9'h0, icon_error});
      send(2'h1, 1'b0, 8'h00);
      chk("test", 10'h0, {9'h0, test_mode});
      for (int i = 0; i < 6; i++) send(2'(i % 3), 1'b1, 8'($urandom));
      u_host.ser(1'b1, 8'ha5, 0);
      repeat (3) @(posedge clk);
      chk("drop", 10'd8, 10'(seen));
      bus_mode <= 2'h3;
      u_host.par(1'b0, 1'b0, 8'h00);
      repeat (3) @(posedge clk);
      chk("none", 10'd8, 10'(seen));
      send(2'h2, 1'b0, 8'h21);
      chk("osc", 10'h1, {8'h0, saver_bit, osc_on});
      send(2'h0, 1'b1, `BLANK_CHAR);
      send(2'h1, 1'b1, 8'h00);
      send(2'h0, 1'b0, 8'h51);
      chk("disp", 10'h2, {8'h0, power_circuit_on, display_on});
      repeat (PWR_WAIT) @(posedge clk);
      send(2'h0, 1'b0, 8'h31);
      chk("disp", 10'h1, {6'h0, icon_on} | display_on);
      exp_i = 10'h0;
      for (int k = 0; k < 4; k++) begin // icons are the last init step
         b = (k == 1) ? 8'he0 : 8'($urandom);
         send(2'h1, 1'b0, 8'h40 | 8'(k));
         send(2'h1, 1'b1, b);
         exp_i = exp_i | icon_bit(k, b);
         chk("icons", exp_i, {6'h0, icon_on});
      end
      send(2'h1, 1'b0, 8'h42);
      send(2'h0, 1'b0, 8'h30);
      chk("end_icon", {5'h0, exp_i[3:0], 1'b0}, {5'h0, icon_on, display_on});
      send(2'h2, 1'b0, 8'h50);
      chk("power", 10'h0, {9'h0, power_circuit_on});
      clear();
      chk("clear", 10'h200, {test_mode, icon_error, display_on, icon_on, 3'h0});
      give_verdict();
   end
   initial begin
      #100000;
      fail_count++;
      give_verdict();
   end
endmodule // lcd_driver_init_sequencer_tb
